// ---- smc_pkg.sv ----
`default_nettype none
package smc_pkg;

    // ==========================================
    // clocks
    localparam int unsigned CLK_HZ     = 200_000_000;
    localparam int unsigned SYSCLK_HZ  = 8_000_000;
    localparam int unsigned SYSCLK_DIV = CLK_HZ / SYSCLK_HZ;
    localparam logic [4:0]  SYSCLK_LAST = 5'(SYSCLK_DIV - 1);
    localparam logic [4:0]  SYSCLK_HIGH = 5'(SYSCLK_DIV / 2);

    // ==========================================
    // register map (byte addresses)
    localparam logic [3:0] OFS_CONFIG  = 4'h0;
    localparam logic [3:0] OFS_PH_LOW  = 4'h4;
    localparam logic [3:0] OFS_PH_HIGH = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'hc;

    // ==========================================
    // topology codes
    localparam logic [2:0] TOPO_STANDALONE = 3'h0;
    localparam logic [2:0] TOPO_MO_MASTER  = 3'h1;
    localparam logic [2:0] TOPO_MO_SLAVE   = 3'h2;
    localparam logic [2:0] TOPO_MP_MASTER  = 3'h3;
    localparam logic [2:0] TOPO_MP_SLAVE   = 3'h4;
    localparam logic [2:0] TOPO_SM_MASTER  = 3'h5;
    localparam logic [2:0] TOPO_SM_SLAVE   = 3'h6;
    localparam logic [2:0] TOPO_UNIMPL     = 3'h7;

    // ==========================================
    // types; field positions follow the packed order, msb first
    typedef struct packed {
        logic       clamp_source_select;
        logic       pedestal_enable;
        logic       regulator_hold_in_sleep;
        logic       regulation_target_select;
        logic       clamp_enable;
        logic [2:0] system_topology_field;
    } smc_cfg_t;

    localparam smc_cfg_t CFG_RESET = 8'h40;
    localparam logic [7:0] PH_RESET = 8'h00;

    typedef struct packed {
        logic sync_out;
        logic clk_out;
        logic share_out;
        logic sync_in;
        logic clk_in;
        logic share_in;
    } smc_pins_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_COUNT
    } smc_ph_state_t;

endpackage
`default_nettype wire

// ---- smc_system_config.sv ----
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - clamp_enable bit 3 enables the amplifier clamp; reset clears it.
// - bit 7 set: clamp from reference pin only; clear: pin plus sampled current.
// - pedestal_enable bit 6 is set by reset; clearing it disables the pedestal.
// - hold bit set at sleep entry keeps the supply regulator fully on.
// - hold bit clear at sleep entry sends the regulator to low-current state.
// - bit 4 clear regulates voltage, bit 4 set regulates output current.
// - topology field bits 2..0 selects standalone, master or slave modes.
// - masters drive the sync pin; clock-including masters also drive 8 MHz clock.
// - code 010 makes sync and system-clock pins inputs from the master.
// - code 110 makes only the sync pin an input; own clock is used.
// - multi-phase master also drives its current sense on the share pin.
// - multi-phase slave takes sync, clock and current share as inputs.
// - slaves delay the received sync by the low/high phase-shift word.
module smc_system_config
    import smc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        link_clk_i,
    input  wire logic        link_rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sleep_i,
    input  wire logic        sw_sync_i,
    input  wire logic        cs_sample_i,
    input  wire logic        sync_pin_i,
    input  wire logic        share_pin_i,
    output logic             sync_pin_o,
    output logic             sync_pin_oe_o,
    output logic             sysclk_pin_o,
    output logic             sysclk_pin_oe_o,
    output logic             share_pin_o,
    output logic             share_pin_oe_o,
    output logic             clamp_enable_o,
    output logic             clamp_pin_only_o,
    output logic             pedestal_enable_o,
    output logic             current_mode_o,
    output logic             regulator_low_o,
    output logic             use_ext_clk_o,
    output logic             share_level_o,
    output logic             phase_sync_o
);

    // ==========================================
    // pin role decode
    function automatic smc_pins_t topo_pins(input logic [2:0] code);
        smc_pins_t p;
        p = '0;
        case (code)
            TOPO_MO_MASTER: p = 6'b110000;
            TOPO_MO_SLAVE:  p = 6'b000110;
            TOPO_MP_MASTER: p = 6'b111000;
            TOPO_MP_SLAVE:  p = 6'b000111;
            TOPO_SM_MASTER: p = 6'b100000;
            TOPO_SM_SLAVE:  p = 6'b000100;
            default:        p = '0;
        endcase
        return p;
    endfunction

    smc_cfg_t      cfg_q;
    logic [7:0]    ph_low_q;
    logic [7:0]    ph_high_q;
    logic          ack_q;
    logic [31:0]   rdat_q;
    smc_pins_t     pins;
    logic          bus_req;
    logic          bus_wr;
    logic [31:0]   rdat_d;

    // modes 010/100 take the master clock, 110 keeps its own
    assign pins = topo_pins(cfg_q.system_topology_field);

    // ==========================================
    // wishbone slave, one wait state, unmapped reads zero
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q     <= CFG_RESET;
            ph_low_q  <= PH_RESET;
            ph_high_q <= PH_RESET;
        end else if (bus_wr) begin
            case (wb_adr_i)
                OFS_CONFIG:  cfg_q     <= smc_cfg_t'(wb_dat_i[7:0]);
                OFS_PH_LOW:  ph_low_q  <= wb_dat_i[7:0];
                OFS_PH_HIGH: ph_high_q <= wb_dat_i[7:0];
                default:     cfg_q     <= cfg_q;
            endcase
        end
    end

    smc_ph_state_t ph_state_q;
    logic          sleep_q;

    always_comb begin
        rdat_d = '0;
        case (wb_adr_i)
            OFS_CONFIG:  rdat_d[7:0] = cfg_q;
            OFS_PH_LOW:  rdat_d[7:0] = ph_low_q;
            OFS_PH_HIGH: rdat_d[7:0] = ph_high_q;
            OFS_STATUS:  rdat_d[8:0] = {sleep_q, regulator_low_o, ph_state_q == PH_COUNT, pins};
            default:     rdat_d = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= bus_req ? rdat_d : '0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ==========================================
    // analog control outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clamp_enable_o    <= 1'b0;
            clamp_pin_only_o  <= 1'b0;
            pedestal_enable_o <= 1'b1;
            current_mode_o    <= 1'b0;
        end else begin
            clamp_enable_o    <= cfg_q.clamp_enable;
            clamp_pin_only_o  <= cfg_q.clamp_source_select;
            pedestal_enable_o <= cfg_q.pedestal_enable;
            current_mode_o    <= cfg_q.regulation_target_select;
        end
    end

    // regulator state is decided at the moment sleep is entered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_q         <= 1'b0;
            regulator_low_o <= 1'b0;
        end else begin
            sleep_q <= sleep_i;
            if (!sleep_i) begin
                regulator_low_o <= 1'b0;
            end else if (!sleep_q) begin
                regulator_low_o <= !cfg_q.regulator_hold_in_sleep;
            end
        end
    end

    // ==========================================
    // 8 MHz system clock out, 12 high / 13 low at 200 MHz
    logic [4:0] div_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= (div_q == SYSCLK_LAST) ? 5'h00 : div_q + 5'h01;
        end
    end

    // ==========================================
    // input pin synchronisers
    logic [1:0] sync_s_q;
    logic [1:0] share_s_q;
    logic       sync_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_s_q    <= '0;
            share_s_q   <= '0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_s_q    <= {sync_s_q[0], sync_pin_i};
            share_s_q   <= {share_s_q[0], share_pin_i};
            sync_prev_q <= sync_s_q[1];
        end
    end

    // ==========================================
    // link domain: sync edges seen on the master clock
    logic [1:0] lk_sync_q;
    logic       lk_prev_q;
    logic       lk_tgl_q;

    always_ff @(posedge link_clk_i) begin
        if (link_rst_i) begin
            lk_sync_q <= '0;
            lk_prev_q <= 1'b0;
            lk_tgl_q  <= 1'b0;
        end else begin
            lk_sync_q <= {lk_sync_q[0], sync_pin_i};
            lk_prev_q <= lk_sync_q[1];
            if (lk_sync_q[1] && !lk_prev_q) begin
                lk_tgl_q <= !lk_tgl_q;
            end
        end
    end

    // toggle crossing back to the core clock
    logic [2:0] tgl_s_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgl_s_q <= '0;
        end else begin
            tgl_s_q <= {tgl_s_q[1:0], lk_tgl_q};
        end
    end

    logic link_edge;
    logic local_edge;
    logic slave_edge;

    assign link_edge  = tgl_s_q[2] != tgl_s_q[1];
    assign local_edge = sync_s_q[1] && !sync_prev_q;
    assign slave_edge = pins.clk_in ? link_edge : (pins.sync_in && local_edge);

    // ==========================================
    // phase shift after the received sync edge
    logic [15:0] ph_cnt_q;
    logic [15:0] ph_word;

    assign ph_word = {ph_high_q, ph_low_q};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_state_q   <= PH_IDLE;
            ph_cnt_q     <= '0;
            phase_sync_o <= 1'b0;
        end else begin
            phase_sync_o <= 1'b0;
            case (ph_state_q)
                PH_IDLE: begin
                    if (slave_edge) begin
                        ph_cnt_q   <= ph_word;
                        ph_state_q <= PH_COUNT;
                    end
                end
                PH_COUNT: begin
                    if (slave_edge) begin
                        ph_cnt_q <= ph_word;
                    end else if (ph_cnt_q == 16'h0000) begin
                        phase_sync_o <= 1'b1;
                        ph_state_q   <= PH_IDLE;
                    end else begin
                        ph_cnt_q <= ph_cnt_q - 16'h0001;
                    end
                end
                default: ph_state_q <= PH_IDLE;
            endcase
        end
    end

    // ==========================================
    // pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_pin_o      <= 1'b0;
            sync_pin_oe_o   <= 1'b0;
            sysclk_pin_o    <= 1'b0;
            sysclk_pin_oe_o <= 1'b0;
            share_pin_o     <= 1'b0;
            share_pin_oe_o  <= 1'b0;
            use_ext_clk_o   <= 1'b0;
            share_level_o   <= 1'b0;
        end else begin
            sync_pin_oe_o   <= pins.sync_out;
            sync_pin_o      <= pins.sync_out && sw_sync_i;
            sysclk_pin_oe_o <= pins.clk_out;
            sysclk_pin_o    <= pins.clk_out && (div_q < SYSCLK_HIGH);
            share_pin_oe_o  <= pins.share_out;
            share_pin_o     <= pins.share_out && cs_sample_i;
            use_ext_clk_o   <= pins.clk_in;
            share_level_o   <= pins.share_in ? share_s_q[1] : cs_sample_i;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_CLAMP_OFF_AT_RESET: assert property (
        $fell(rst_i) |-> !clamp_enable_o && !cfg_q.clamp_enable
    ) else $error("clamp not disabled after reset");

    AST_CLAMP_SOURCE: assert property (
        bus_wr && wb_adr_i == OFS_CONFIG |-> ##2 clamp_pin_only_o == $past(wb_dat_i[7], 2)
    ) else $error("clamp source does not follow bit 7");

    AST_PEDESTAL_AT_RESET: assert property (
        $fell(rst_i) |-> pedestal_enable_o && cfg_q.pedestal_enable
    ) else $error("pedestal not enabled after reset");

    AST_REG_HOLD: assert property (
        $rose(sleep_i) && cfg_q.regulator_hold_in_sleep |=> !regulator_low_o [*2]
    ) else $error("regulator dropped despite hold");

    AST_REG_LOW: assert property (
        $rose(sleep_i) && !cfg_q.regulator_hold_in_sleep |=> regulator_low_o
    ) else $error("regulator not lowered in sleep");

    AST_REG_TARGET: assert property (
        bus_wr && wb_adr_i == OFS_CONFIG |-> ##2 current_mode_o == $past(wb_dat_i[4], 2)
    ) else $error("regulation target does not follow bit 4");

    // only whole high phases count; losing the clock role abandons the check
    AST_SYSCLK_HIGH: assert property (
        disable iff (rst_i || !pins.clk_out)
        $rose(sysclk_pin_o) && div_q == 5'h01
        |-> sysclk_pin_o [*8] ##1 sysclk_pin_o [*4] ##1 !sysclk_pin_o
    ) else $error("system clock high phase wrong");

    AST_SLAVE_CLOCK_IN: assert property (
        cfg_q.system_topology_field == TOPO_MO_SLAVE && $stable(cfg_q)
        |=> !sync_pin_oe_o && !sysclk_pin_oe_o && use_ext_clk_o
    ) else $error("code 010 pins not inputs");

    AST_SLAVE_SYNC_ONLY: assert property (
        cfg_q.system_topology_field == TOPO_SM_SLAVE && $stable(cfg_q)
        |=> !sync_pin_oe_o && !use_ext_clk_o
    ) else $error("code 110 pin roles wrong");

    AST_MP_MASTER: assert property (
        cfg_q.system_topology_field == TOPO_MP_MASTER && $stable(cfg_q)
        |=> sync_pin_oe_o && sysclk_pin_oe_o && share_pin_oe_o
    ) else $error("multi-phase master not driving pins");

    AST_MP_SLAVE: assert property (
        cfg_q.system_topology_field == TOPO_MP_SLAVE && $stable(cfg_q)
        |=> !sync_pin_oe_o && !sysclk_pin_oe_o && !share_pin_oe_o && use_ext_clk_o
    ) else $error("multi-phase slave pins not inputs");

    AST_PHASE_DELAY: assert property (
        ph_state_q == PH_COUNT && ph_cnt_q == 16'h0002 && !slave_edge ##1 !slave_edge ##1 !slave_edge
        |=> phase_sync_o
    ) else $error("phase shifted sync late or missing");

    AST_UNIMPL_PLAIN: assert property (
        cfg_q.system_topology_field == TOPO_UNIMPL && $stable(cfg_q)
        |=> !sync_pin_oe_o && !sysclk_pin_oe_o && !share_pin_oe_o && !use_ext_clk_o
    ) else $error("code 111 changed pin roles");

endmodule
`default_nettype wire

// ---- smc_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// peer controller acting as multi-phase master
module smc_peer_model (
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic cs_i,
    output logic      link_clk_o,
    output logic      sync_o,
    output logic      share_o
);
    logic ck = 1'b0;

    initial begin
        sync_o  = 1'b0;
        share_o = 1'b0;
        #7;
        forever #15 ck = ~ck;
    end

    // clock on the shared pin only runs while the peer is active
    assign link_clk_o = run_i & ck;

    // shared current sense; a released line toggles every cycle
    always @(posedge clk_i) share_o <= run_i ? cs_i : ~share_o;

    // switching sync pulse, wide enough for two peer clock edges
    task automatic pulse();
        @(posedge clk_i);
        sync_o <= 1'b1;
        repeat (16) @(posedge clk_i);
        sync_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import smc_pkg::*;

    // ==========================================
    // stimulus and wiring
    logic        clk_i = 1'b0, rst_i = 1'b1, link_rst = 1'b1, run = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [3:0]  wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic        sleep = 1'b0, sw_sync = 1'b0, cs_sample = 1'b0, peer_cs = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, sync_pin_o, sync_pin_oe_o, sysclk_pin_o, sysclk_pin_oe_o;
    logic        share_pin_o, share_pin_oe_o, clamp_enable_o, clamp_pin_only_o;
    logic        pedestal_enable_o, current_mode_o, regulator_low_o, use_ext_clk_o;
    logic        share_level_o, phase_sync_o, peer_clk, peer_sync, peer_share;
    wire         sync_w  = sync_pin_oe_o ? sync_pin_o : peer_sync;
    wire         share_w = share_pin_oe_o ? share_pin_o : peer_share;
    wire         clk_w   = sysclk_pin_oe_o ? sysclk_pin_o : peer_clk;
    int          error_cnt = 0, checked = 0;
    logic [3:0]  exp_t [8] = '{4'h0, 4'hc, 4'h1, 4'he, 4'h1, 4'h8, 4'h0, 4'h0};

    initial forever #2.5 clk_i = ~clk_i;

    smc_system_config DUT (
        .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(clk_w), .link_rst_i(link_rst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sleep_i(sleep), .sw_sync_i(sw_sync), .cs_sample_i(cs_sample),
        .sync_pin_i(sync_w), .share_pin_i(share_w), .sync_pin_o(sync_pin_o),
        .sync_pin_oe_o(sync_pin_oe_o), .sysclk_pin_o(sysclk_pin_o),
        .sysclk_pin_oe_o(sysclk_pin_oe_o), .share_pin_o(share_pin_o),
        .share_pin_oe_o(share_pin_oe_o), .clamp_enable_o(clamp_enable_o),
        .clamp_pin_only_o(clamp_pin_only_o), .pedestal_enable_o(pedestal_enable_o),
        .current_mode_o(current_mode_o), .regulator_low_o(regulator_low_o),
        .use_ext_clk_o(use_ext_clk_o), .share_level_o(share_level_o),
        .phase_sync_o(phase_sync_o)
    );

    smc_peer_model peer (
        .clk_i(clk_i), .run_i(run), .cs_i(peer_cs),
        .link_clk_o(peer_clk), .sync_o(peer_sync), .share_o(peer_share)
    );

    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [7:0] dat,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= {24'h0, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) error_cnt++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb_xfer(1'b1, adr, dat, d);
    endtask

    task automatic phase_lat(input logic [7:0] nlo, output int cnt);
        wr(OFS_PH_LOW, nlo);
        wr(OFS_PH_HIGH, 8'h00);
        cnt = 0;
        fork
            peer.pulse(); // slave phase counter reloads the phase word on each received rising pulse edge
            while (phase_sync_o !== 1'b1 && cnt < 300) begin
                @(posedge clk_i);
                cnt++;
            end
        join
        cyc(40);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [31:0] d;
        chk({pedestal_enable_o, clamp_enable_o}, 2'b10);
        wb_xfer(1'b0, OFS_CONFIG, 8'h00, d);
        chk(d, 32'h40);
        wb_xfer(1'b1, 4'h2, 8'hff, d);
        wb_xfer(1'b0, 4'h2, 8'h00, d);
        chk(d, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_cfg_bits();
        wr(OFS_CONFIG, 8'h98);
        cyc(3);
        chk({clamp_pin_only_o, pedestal_enable_o, current_mode_o, clamp_enable_o}, 4'hb);
        wr(OFS_CONFIG, 8'h40); // pedestal back on
        cyc(3);
        chk({clamp_pin_only_o, pedestal_enable_o, current_mode_o, clamp_enable_o}, 4'h4);
        $display("test cfg bits done");
    endtask

    task automatic t_topo();
        logic [31:0] d;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CONFIG, {5'b01000, 3'(c)});
            cyc(3);
            chk({sync_pin_oe_o, sysclk_pin_oe_o, share_pin_oe_o, use_ext_clk_o}, exp_t[c]);
            wb_xfer(1'b0, OFS_CONFIG, 8'h00, d);
            chk(d, {24'h0, 5'b01000, 3'(c)});
        end
        $display("test topology done");
    endtask

    task automatic t_master();
        int   r1, r2;
        logic p;
        r1 = -1;
        r2 = -1;
        p = 1'b1;
        wr(OFS_CONFIG, {5'b01000, TOPO_MO_MASTER});
        sw_sync <= 1'b1;
        cyc(3);
        chk(sync_pin_o, 1);
        sw_sync <= 1'b0;
        cyc(3);
        chk(sync_pin_o, 0);
        for (int n = 0; n < 100; n++) begin
            @(posedge clk_i);
            if (sysclk_pin_o === 1'b1 && p === 1'b0) begin
                if (r1 < 0) r1 = n;
                else if (r2 < 0) r2 = n;
            end
            p = sysclk_pin_o;
        end
        chk(r2 - r1, SYSCLK_DIV);
        wr(OFS_CONFIG, {5'b01000, TOPO_MP_MASTER});
        cs_sample <= 1'b1;
        cyc(3);
        chk({share_pin_oe_o, share_pin_o}, 2'b11);
        cs_sample <= 1'b0;
        cyc(3);
        chk(share_pin_o, 0);
        $display("test master done");
    endtask

    task automatic t_sleep();
        logic [31:0] d;
        wr(OFS_CONFIG, 8'h40);
        sleep <= 1'b1;
        cyc(3);
        chk(regulator_low_o, 1);
        wb_xfer(1'b0, OFS_STATUS, 8'h00, d);
        chk(d, 32'h180);
        sleep <= 1'b0;
        cyc(3);
        chk(regulator_low_o, 0);
        wr(OFS_CONFIG, 8'h60);
        sleep <= 1'b1;
        cyc(3);
        chk(regulator_low_o, 0);
        sleep <= 1'b0;
        cyc(3);
        $display("test sleep done");
    endtask

    task automatic t_phase();
        int a, b;
        wr(OFS_CONFIG, {5'b01000, TOPO_STANDALONE});
        phase_lat(8'h05, a);
        chk(a, 300);
        wr(OFS_CONFIG, {5'b01000, TOPO_SM_SLAVE});
        phase_lat(8'h05, a);
        phase_lat(8'h14, b);
        chk(a > 7 && a < 16, 1);
        chk(b - a, 15);
        $display("test phase done");
    endtask

    task automatic t_mp_slave();
        int a;
        run <= 1'b1;
        wr(OFS_CONFIG, {5'b01010, TOPO_MP_SLAVE}); // slave selects current regulation
        cs_sample <= 1'b0;
        peer_cs <= 1'b1;
        cyc(8);
        chk({use_ext_clk_o, current_mode_o, share_level_o}, 3'b111);
        peer_cs <= 1'b0;
        cyc(8);
        chk(share_level_o, 0);
        phase_lat(8'h05, a);
        chk(a < 40, 1);
        run <= 1'b0;
        wr(OFS_CONFIG, 8'h40);
        $display("test multi-phase slave done");
    endtask

    // ==========================================
    // sequence and verdict
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        cyc(6);
        rst_i <= 1'b0;
        cyc(14);
        link_rst <= 1'b0;
        run <= 1'b0;
        cyc(2);
        t_reset();
        t_cfg_bits();
        t_topo();
        t_master();
        t_sleep();
        t_phase();
        t_mp_slave();
        test_done();
    end

    initial begin
        #60000;
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
